// >>> hdl/isolated_switch_channel_output_logic.sv
/*
 * Per-channel output decision logic of an isolated smart switch: drives
 * the switch outputs, status lamps, fault indicator and field supply
 * warning from host inputs, supply states and fault conditions.
 * Assumes all inputs are asynchronous pins or comparator levels that the
 * host and sensors hold at defined levels; open-drain outputs are
 * resolved to wires outside this module.
 */
`include "switch_ch_defines.svh"

// Contract
// - outputs use inputs, states and previous supply
// - outputs follow causes; high input means true
// - clean supply: on only if input and enable
// - classify field supply by two thresholds
// - unpowered field supply forces fault detected
// - fault clears itself when conditions clear
// - warning changes only after state persists
// - unpowered warning depends on previous state
// - over-temperature while on: no immediate shutdown
// - over-temperature while off: blocks turning on
// - over-voltage leaves switching behaviour unchanged
// - indicators active-low open-drain; fault undefined unpowered
module isolated_switch_channel_output_logic
    import switch_ch_pkg::*;
#(
    parameter int NUM_CH   = `NUM_CH_DEF,
    parameter int MEAS_CYC = `FIELD_MEAS_CYC
) (
    input  wire logic              SYS_CLK_I,
    input  wire logic              RST_I,
    input  wire logic [NUM_CH-1:0] CHANNEL_INPUT_I,
    input  wire logic              OUTPUT_ENABLE_I,
    input  wire logic              LOGIC_SUPPLY_OK_I,
    input  wire logic              FIELD_ABOVE_LOW_I,
    input  wire logic              FIELD_ABOVE_HIGH_I,
    input  wire logic              FAULT_COND_I,
    input  wire logic [NUM_CH-1:0] OVER_TEMP_I,
    input  wire logic [NUM_CH-1:0] OVER_VOLT_I,
    output logic      [NUM_CH-1:0] SWITCH_OUTPUT_O,
    output logic      [NUM_CH-1:0] STATUS_LAMP_N_O,
    output logic      [NUM_CH-1:0] STATUS_LAMP_N_OE_O,
    output logic                   FAULT_INDICATOR_N_O,
    output logic                   FAULT_INDICATOR_N_OE_O,
    output logic                   FIELD_SUPPLY_LOW_WARN_N_O,
    output logic                   FIELD_SUPPLY_LOW_WARN_N_OE_O
);

    generate
        if (NUM_CH < 1) begin : g_chk
            $error("switch channel logic: NUM_CH must be at least 1");
        end
    endgenerate

    // ======================================================================
    // input synchronisation
    localparam int SW = 3 * NUM_CH + 5;
    localparam int P_OT = NUM_CH;
    localparam int P_OV = 2 * NUM_CH;
    localparam int P_EN = 3 * NUM_CH;

    logic [SW-1:0]     pins_s;
    logic [NUM_CH-1:0] ch_s;
    logic [NUM_CH-1:0] ot_s;
    logic [NUM_CH-1:0] ov_s;
    logic              oe_s;
    logic              logic_ok_s;
    logic              above_low_s;
    logic              above_high_s;
    logic              fault_cond_s;

    // every pin shares one synchroniser so all of them see equal latency,
    // which keeps input and state changes aligned
    // limitation: a pin pulse seen at only one clock edge never reaches the logic
    pin_sync3 #(
        .W (SW)
    ) pin_sync3_i (
        .clk_i   (SYS_CLK_I),
        .rst_i   (RST_I),
        .pin_i   ({FAULT_COND_I, FIELD_ABOVE_HIGH_I, FIELD_ABOVE_LOW_I,
                   LOGIC_SUPPLY_OK_I, OUTPUT_ENABLE_I,
                   OVER_VOLT_I, OVER_TEMP_I, CHANNEL_INPUT_I}),
        .level_o (pins_s)
    );

    assign ch_s         = pins_s[NUM_CH-1:0];
    assign ot_s         = pins_s[P_OT +: NUM_CH];
    assign ov_s         = pins_s[P_OV +: NUM_CH];
    assign oe_s         = pins_s[P_EN];
    assign logic_ok_s   = pins_s[P_EN + 1];
    assign above_low_s  = pins_s[P_EN + 2];
    assign above_high_s = pins_s[P_EN + 3];
    assign fault_cond_s = pins_s[P_EN + 4];

    // ======================================================================
    // field supply state
    field_state_t fs_raw;
    field_state_t fs_cur;
    field_state_t fs_prev;

    field_supply_qual #(
        .MEAS_CYC (MEAS_CYC)
    ) field_supply_qual_i (
        .clk_i        (SYS_CLK_I),
        .rst_i        (RST_I),
        .above_low_i  (above_low_s),
        .above_high_i (above_high_s),
        .raw_o        (fs_raw),
        .cur_o        (fs_cur),
        .prev_o       (fs_prev)
    );

    // ======================================================================
    // decoding helpers
    function automatic logic warn_decode(field_state_t cur, field_state_t prev);
        // an unpowered supply keeps the warning only when it fell out of
        // the warning state
        case (cur)
            FS_WARN: warn_decode = 1'b1;
            FS_NP:   warn_decode = (prev == FS_WARN);
            FS_PWR:  warn_decode = 1'b0;
            default: warn_decode = 1'b0;
        endcase
    endfunction

    function automatic logic want_on(logic ch, logic en);
        // high on both pins is the true request
        want_on = ch & en;
    endfunction

    // ======================================================================
    // fault state
    logic field_np;
    logic fault_det;
    logic hard_fault;

    // the fault indicator is shared: a fault on any one channel asserts it,
    // so the host cannot tell from it which channel is hit
    assign field_np   = (fs_raw == FS_NP);
    // recomputed every cycle, so it drops once every cause is gone
    assign fault_det  = field_np | fault_cond_s | (|ot_s) | (|ov_s);
    // over-temperature and over-voltage are left out: over-temperature shapes the switching
    // decision below and feeds the fault indicator, and over-voltage only feeds the fault indicator
    assign hard_fault = field_np | fault_cond_s | ~logic_ok_s;

    // ======================================================================
    // output state
    typedef struct packed {
        logic [NUM_CH-1:0] sw;
        logic [NUM_CH-1:0] lamp;
        logic              fault_indicator_n;
        logic              warn;
    } out_state_t;

    out_state_t st_r;
    out_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        for (int c = 0; c < NUM_CH; c++) begin
            // an over-temperature switch already on stays on; one that is
            // off may not come on
            st_nxt.sw[c] = want_on(ch_s[c], oe_s) & ~hard_fault
                         & (st_r.sw[c] | ~ot_s[c]);
        end
        // the lamp shows the true switch status
        st_nxt.lamp = st_nxt.sw;
        // unpowered logic side: indicator left released
        st_nxt.fault_indicator_n  = logic_ok_s & fault_det;
        st_nxt.warn = logic_ok_s & warn_decode(fs_cur, fs_prev);
    end

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ======================================================================
    // pins: open-drain indicators pull low while asserted
    assign SWITCH_OUTPUT_O              = st_r.sw;
    assign STATUS_LAMP_N_O              = '0;
    assign STATUS_LAMP_N_OE_O           = st_r.lamp;
    assign FAULT_INDICATOR_N_O          = 1'b0;
    assign FAULT_INDICATOR_N_OE_O       = st_r.fault_indicator_n;
    assign FIELD_SUPPLY_LOW_WARN_N_O    = 1'b0;
    assign FIELD_SUPPLY_LOW_WARN_N_OE_O = st_r.warn;

    // ======================================================================
    // assertions
    default clocking cb @(posedge SYS_CLK_I);
    endclocking

    default disable iff (RST_I);

    logic clean0;
    assign clean0 = logic_ok_s & ~field_np & ~fault_cond_s & ~ot_s[0];

    sw_follow_a: assert property (
        clean0 |=> (SWITCH_OUTPUT_O[0] == $past(ch_s[0] & oe_s)))
        else $error("switch output does not follow input and enable");

    np_fault_a: assert property (
        (logic_ok_s && field_np) |=> FAULT_INDICATOR_N_OE_O)
        else $error("unpowered field supply did not assert fault");

    fault_clear_a: assert property (
        (logic_ok_s && !fault_det) |=> !FAULT_INDICATOR_N_OE_O)
        else $error("fault indicator did not clear on its own");

    np_off_a: assert property (
        (field_np || fault_cond_s) |=> (SWITCH_OUTPUT_O == '0)
            && (STATUS_LAMP_N_OE_O == '0))
        else $error("output on while a hard fault is present");

    ot_hold_a: assert property (
        (SWITCH_OUTPUT_O[0] && ot_s[0] && want_on(ch_s[0], oe_s)
            && !hard_fault) |=> SWITCH_OUTPUT_O[0])
        else $error("over-temperature shut the output down at once");

    ot_block_a: assert property (
        (!SWITCH_OUTPUT_O[0] && ot_s[0]) |=> !SWITCH_OUTPUT_O[0])
        else $error("over-temperature output turned on");

    ov_normal_a: assert property (
        (ov_s[0] && clean0) |=> (SWITCH_OUTPUT_O[0] == $past(oe_s & ch_s[0]))
            && FAULT_INDICATOR_N_OE_O)
        else $error("over-voltage altered switching");

    warn_state_a: assert property (
        (logic_ok_s && fs_cur == FS_WARN) |=> FIELD_SUPPLY_LOW_WARN_N_OE_O)
        else $error("warning not asserted in warning state");

    warn_prev_a: assert property (
        (logic_ok_s && fs_cur == FS_NP) |=>
            (FIELD_SUPPLY_LOW_WARN_N_OE_O == ($past(fs_prev) == FS_WARN)))
        else $error("unpowered warning ignores previous state");

    warn_pwr_a: assert property (
        (fs_cur == FS_PWR) [*2] |-> !FIELD_SUPPLY_LOW_WARN_N_OE_O)
        else $error("warning asserted with supply powered");

    logic_off_a: assert property (
        !logic_ok_s |=> !FAULT_INDICATOR_N_OE_O && (SWITCH_OUTPUT_O == '0)
            && !FIELD_SUPPLY_LOW_WARN_N_OE_O && (FAULT_INDICATOR_N_O == 1'b0))
        else $error("outputs active with logic supply down");

    lamp_pair_a: assert property (
        $rose(SWITCH_OUTPUT_O[0]) |-> $rose(STATUS_LAMP_N_OE_O[0])
            && $past(want_on(ch_s[0], oe_s)))
        else $error("lamp and switch out of step");

    sw_on_c:    cover property (clean0 && ch_s[0] && oe_s ##1 SWITCH_OUTPUT_O[0]);
    ot_block_c: cover property (ot_s[0] && want_on(ch_s[0], oe_s)
                                && !SWITCH_OUTPUT_O[0] && !hard_fault);
    warn_np_c:  cover property (fs_cur == FS_NP && fs_prev == FS_WARN
                                ##1 FIELD_SUPPLY_LOW_WARN_N_OE_O);
    clear_c:    cover property (FAULT_INDICATOR_N_OE_O ##1
                                !FAULT_INDICATOR_N_OE_O);
    hold_c:     cover property (SWITCH_OUTPUT_O[0] && ot_s[0] ##1 SWITCH_OUTPUT_O[0]);

    // ======================================================================
    // per-channel checks: the switching properties above, save np_off_a and logic_off_a, watch channel 0 only; these
    // repeat the switching rules on every channel, so a fault confined to a
    // higher channel index cannot slip through
    generate
        for (genvar g = 0; g < NUM_CH; g++) begin : g_ch_chk
            logic clean_g;

            // no hard fault and no over-temperature on this channel
            assign clean_g = logic_ok_s & ~field_np & ~fault_cond_s & ~ot_s[g];

            ch_follow_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
                clean_g |=> (SWITCH_OUTPUT_O[g] == $past(want_on(ch_s[g], oe_s))))
                else $error("channel output does not follow its request");

            ch_hold_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
                (SWITCH_OUTPUT_O[g] && ot_s[g] && want_on(ch_s[g], oe_s) && !hard_fault)
                    |=> SWITCH_OUTPUT_O[g])
                else $error("over-temperature channel shut down at once");

            ch_block_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
                (!SWITCH_OUTPUT_O[g] && ot_s[g]) |=> !SWITCH_OUTPUT_O[g])
                else $error("over-temperature channel turned on");

            ch_ov_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
                (ov_s[g] && clean_g) |=> FAULT_INDICATOR_N_OE_O
                    && (SWITCH_OUTPUT_O[g] == $past(want_on(ch_s[g], oe_s))))
                else $error("over-voltage altered channel switching");

            ch_off_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
                hard_fault |=> !SWITCH_OUTPUT_O[g] && !STATUS_LAMP_N_OE_O[g])
                else $error("channel on during a hard fault");
        end
    endgenerate

endmodule

// >>> hdl/switch_ch_defines.svh
/*
 * Timing and structure constants for the switch channel output logic.
 * Assumes a single 10 MHz system clock; included by its bare name.
 */
`ifndef SWITCH_CH_DEFINES_SVH
`define SWITCH_CH_DEFINES_SVH

// ==========================================================================
// clock and timing
`define CLK_PERIOD_NS   32'h0000_0064
// field supply must hold a state this long before the warning may follow it
`define FIELD_MEAS_NS   32'h0000_03E8
`define FIELD_MEAS_CYC  ((`FIELD_MEAS_NS + `CLK_PERIOD_NS - 32'h0000_0001) / `CLK_PERIOD_NS)

// ==========================================================================
// structure
`define NUM_CH_DEF      32'h0000_0002

`endif

// >>> hdl/switch_ch_pkg.sv
/*
 * Types shared by the switch channel output logic.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package switch_ch_pkg;

    // ======================================================================
    // field supply classification
    typedef enum logic [1:0] {
        FS_NP   = 2'b00,
        FS_WARN = 2'b01,
        FS_PWR  = 2'b10
    } field_state_t;

endpackage

// >>> hdl/pin_sync3.sv
/*
 * Three-stage pin synchroniser with agreement filter.
 * Assumes asynchronous inputs held at defined levels by the far side.
 */
module pin_sync3 #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level_o
);

    generate
        if (W < 1) begin : g_chk
            $error("pin_sync3: W must be at least 1");
        end
    endgenerate

    // ======================================================================
    // state
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] stable;
    } sync_state_t;

    sync_state_t st_r;
    sync_state_t st_nxt;

    // a change is taken only once stages two and three agree
    always_comb begin
        st_nxt        = st_r;
        st_nxt.s1     = pin_i;
        st_nxt.s2     = st_r.s1;
        st_nxt.s3     = st_r.s2;
        st_nxt.stable = (~(st_r.s2 ^ st_r.s3) & st_r.s3)
                      | ((st_r.s2 ^ st_r.s3) & st_r.stable);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level_o = st_r.stable;

endmodule

// >>> hdl/field_supply_qual.sv
/*
 * Field supply classifier and persistence qualifier.
 * Assumes synchronised comparator levels for the two supply thresholds.
 */
`include "switch_ch_defines.svh"

module field_supply_qual
    import switch_ch_pkg::*;
#(
    parameter int MEAS_CYC = `FIELD_MEAS_CYC
) (
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    input  wire logic   above_low_i,
    input  wire logic   above_high_i,
    output field_state_t raw_o,
    output field_state_t cur_o,
    output field_state_t prev_o
);

    localparam int CW = $clog2(MEAS_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(MEAS_CYC - 1);

    generate
        if (MEAS_CYC < 1) begin : g_chk
            $error("field_supply_qual: MEAS_CYC must be at least 1");
        end
    endgenerate

    // ======================================================================
    // state
    typedef struct packed {
        field_state_t  cand;
        logic [CW-1:0] cnt;
        field_state_t  cur;
        field_state_t  prev;
    } qual_state_t;

    qual_state_t  st_r;
    qual_state_t  st_nxt;
    field_state_t raw;

    // classification by the two thresholds
    always_comb begin
        if (!above_low_i) begin
            raw = FS_NP;
        end else if (!above_high_i) begin
            raw = FS_WARN;
        end else begin
            raw = FS_PWR;
        end
    end

    // a new state is committed only after it held for MEAS_CYC cycles;
    // a shorter excursion restarts the count and leaves cur alone
    always_comb begin
        st_nxt = st_r;
        if (raw != st_r.cand) begin
            st_nxt.cand = raw;
            st_nxt.cnt  = '0;
        end else if (st_r.cnt != LAST) begin
            st_nxt.cnt = st_r.cnt + CW'(1);
        end else if (raw != st_r.cur) begin
            st_nxt.prev = st_r.cur; // one-step history
            st_nxt.cur  = raw;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= '{cand: FS_NP, cnt: '0, cur: FS_NP, prev: FS_NP};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign raw_o  = raw;
    assign cur_o  = st_r.cur;
    assign prev_o = st_r.prev;

    // ======================================================================
    // assertions
    qual_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_r.cur != $past(st_r.cur)) |->
            ($past(st_r.cnt) == LAST) && ($past(raw) == st_r.cur))
        else $error("qualified field state moved without a full hold");

    qual_hist_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_r.cur != $past(st_r.cur)) |-> (st_r.prev == $past(st_r.cur)))
        else $error("previous field state not kept on change");

endmodule

// >>> tb/host_ctrl_model.sv
/*
 * Host controller model: drives the channel requests and the common
 * output enable of the switch channel logic.
 * Assumes the bench hands it the wanted levels; it changes its pins only
 * at the falling edge so the device never samples a moving level.
 */
module host_ctrl_model #(
    parameter int NUM_CH = 2
) (
    input  wire logic              clk_i,
    input  wire logic [NUM_CH-1:0] req_ch_i,
    input  wire logic              req_oe_i,
    output logic      [NUM_CH-1:0] ch_o,
    output logic                   oe_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // ======================================================================
    // pin drive: always a defined level, never left floating
    initial begin
        ch_o = '0;
        oe_o = 1'b0;
        forever begin
            @(negedge clk_i);
            ch_o <= req_ch_i;
            oe_o <= req_oe_i;
        end
    end
endmodule

// >>> tb/isolated_switch_channel_output_logic_tb.sv
/*
 * Self-checking bench for the switch channel output logic.
 * Assumes the design's registered outputs settle well within SETTLE cycles
 * of an input change; open-drain pins are resolved here with pull-ups.
 */
module isolated_switch_channel_output_logic_tb
    import switch_ch_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int SETTLE = 16;

    logic         clk;
    logic         rst;
    logic [1:0]   req_ch;
    logic         req_oe;
    logic [1:0]   ch;
    logic         oe;
    logic         lok;
    logic         lo;
    logic         hi;
    logic         fc;
    logic [1:0]   ot;
    logic [1:0]   ov;
    logic [1:0]   sw;
    logic [1:0]   lamp_n;
    logic [1:0]   lamp_oe;
    logic         flt_n;
    logic         flt_oe;
    logic         warn_n;
    logic         warn_oe;
    wire  [1:0]   lamp_w = ~lamp_oe & ~lamp_n;
    wire          flt_w  = ~(flt_oe & ~flt_n);
    wire          warn_w = ~(warn_oe & ~warn_n);
    int           failures;
    int           check_count;
    logic [5:0]   exp_q[$];
    logic [5:0]   e6;
    logic [1:0]   sw_m;
    field_state_t cur_q;
    field_state_t prev_q;
    event         chk_ev;

    // ======================================================================
    // device and host
    isolated_switch_channel_output_logic #(.NUM_CH(2), .MEAS_CYC(3))
        isolated_switch_channel_output_logic_i (
        .SYS_CLK_I                   (clk),
        .RST_I                       (rst),
        .CHANNEL_INPUT_I             (ch),
        .OUTPUT_ENABLE_I             (oe),
        .LOGIC_SUPPLY_OK_I           (lok),
        .FIELD_ABOVE_LOW_I           (lo),
        .FIELD_ABOVE_HIGH_I          (hi),
        .FAULT_COND_I                (fc),
        .OVER_TEMP_I                 (ot),
        .OVER_VOLT_I                 (ov),
        .SWITCH_OUTPUT_O             (sw),
        .STATUS_LAMP_N_O             (lamp_n),
        .STATUS_LAMP_N_OE_O          (lamp_oe),
        .FAULT_INDICATOR_N_O         (flt_n),
        .FAULT_INDICATOR_N_OE_O      (flt_oe),
        .FIELD_SUPPLY_LOW_WARN_N_O   (warn_n),
        .FIELD_SUPPLY_LOW_WARN_N_OE_O(warn_oe)
    );

    host_ctrl_model #(.NUM_CH(2)) host_ctrl_model_i (
        .clk_i   (clk),
        .req_ch_i(req_ch),
        .req_oe_i(req_oe),
        .ch_o    (ch),
        .oe_o    (oe)
    );

    // ======================================================================
    // helpers
    task automatic check(input logic [1:0] seen, input logic [1:0] expv);
        check_count++;
        if (seen !== expv) begin
            failures++;
            $display("[ERR] %0t output mismatch seen %b expected %b", $time, seen, expv);
        end
    endtask

    task automatic final_report();
        if (failures == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // one held input state; the expectation is reckoned from the truth table
    task automatic apply(input logic l, input field_state_t fs, input logic f,
                         input logic [1:0] t, input logic [1:0] v,
                         input logic [1:0] c, input logic e);
        logic np;
        logic fault_indicator_n;
        logic warn;
        // the host model copies its request at the falling edge, so it is set
        // half a cycle early to reach the pins together with the others
        @(posedge clk);
        req_ch = c;
        req_oe = e;
        @(negedge clk);
        lok = l;
        lo = (fs != FS_NP);
        hi = (fs == FS_PWR);
        fc = f;
        ot = t;
        ov = v;
        if (fs != cur_q) begin
            prev_q = cur_q;
            cur_q = fs;
        end
        np = (fs == FS_NP);
        for (int i = 0; i < 2; i++) begin
            sw_m[i] = l & ~np & ~f & c[i] & e & (sw_m[i] | ~t[i]);
        end
        fault_indicator_n = l & (np | f | (|t) | (|v));
        warn = l & ((cur_q == FS_WARN) | ((cur_q == FS_NP) & (prev_q == FS_WARN)));
        repeat (SETTLE) @(negedge clk);
        exp_q.push_back({sw_m, ~sw_m, ~fault_indicator_n, ~warn});
        ->chk_ev;
    endtask

    // ======================================================================
    // clock, result watcher, watchdog
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        forever begin
            @(chk_ev);
            e6 = exp_q.pop_front();
            check(sw, e6[5:4]);
            check(lamp_w, e6[3:2]);
            check({1'b0, flt_w}, {1'b0, e6[1]});
            check({1'b0, warn_w}, {1'b0, e6[0]});
        end
    end

    initial begin
        repeat (4000) @(posedge clk);
        failures++;
        final_report();
    end

    // ======================================================================
    // main sequence
    initial begin
        rst = 1'b1;
        {req_ch, req_oe, lok, lo, hi, fc, ot, ov} = '0;
        failures = 0;
        check_count = 0;
        sw_m = '0;
        cur_q = FS_NP;
        prev_q = FS_NP;
        void'($urandom(32'hdb53_2076));
        repeat (6) @(negedge clk);
        rst = 1'b0;
        apply(1, FS_NP, 0, 0, 0, 2'b11, 1);
        apply(1, FS_PWR, 0, 0, 0, 2'b11, 1);
        for (int k = 0; k < 8; k++) begin
            apply(1, FS_PWR, 0, 0, 0, 2'($urandom), 1'($urandom));
        end
        apply(1, FS_PWR, 0, 0, 0, 2'b11, 1);
        // brief dip to warning, shorter than the measurement time
        @(negedge clk);
        hi = 1'b0;
        repeat (2) @(negedge clk);
        hi = 1'b1;
        apply(1, FS_PWR, 0, 0, 0, 2'b11, 1);
        apply(1, FS_WARN, 0, 0, 0, 2'b11, 1);
        apply(1, FS_NP, 0, 0, 0, 2'b11, 1);
        apply(1, FS_PWR, 0, 0, 0, 2'b11, 1);
        apply(1, FS_PWR, 0, 2'b01, 0, 2'b11, 1);
        apply(1, FS_PWR, 0, 2'b01, 0, 2'b10, 1);
        apply(1, FS_PWR, 0, 2'b01, 0, 2'b11, 1);
        apply(1, FS_PWR, 0, 0, 2'b11, 2'b11, 1);
        apply(1, FS_PWR, 0, 0, 2'b11, 2'b11, 0);
        apply(1, FS_PWR, 1, 0, 0, 2'b11, 1);
        apply(1, FS_PWR, 0, 0, 0, 2'b11, 1);
        apply(0, FS_PWR, 0, 0, 0, 2'b11, 1);
        apply(1, FS_WARN, 0, 0, 0, 2'b01, 1);
        // reset in mid-run: qualified history starts again from not powered
        @(negedge clk);
        rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        sw_m = '0;
        cur_q = FS_NP;
        prev_q = FS_NP;
        apply(1, FS_PWR, 0, 0, 0, 2'b11, 1);
        // let the watcher take the last note before closing
        @(negedge clk);
        if (exp_q.size() != 0) begin
            failures++;
        end
        final_report();
    end
endmodule
